// file: design/crw_clock_reset_watchdog.v
`timescale 1ns/1ps
`default_nettype none
`include "crw_defines.vh"

module crw_clock_reset_watchdog #(
   parameter TICKS_PER_MS = `CRW_TICKS_PER_MS,
   parameter WDOG_MS = `CRW_WDOG_PERIOD_MS,
   parameter STRETCH_MS = `CRW_RESET_STRETCH_MS
) (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   output reg [1:0] s_axi_bresp,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   input wire [31:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   input wire crystal_input,
   output reg crystal_output,
   output reg oscillator_power_down,
   input wire emulation_mode,
   input wire processor_clock_pin_in,
   output reg processor_clock_pin_out,
   output reg processor_clock_pin_oe,
   output reg buffered_source_clock_out,
   output reg low_rate_clock_out,
   output reg baud_clock_out,
   output reg sci_baud_tick,
   input wire pulse_modulator_one,
   input wire pulse_modulator_two,
   input wire serial_latch_two_strobe,
   output reg pin_output_one,
   output reg pin_output_two,
   output reg pin_output_six_n,
   output reg pin_output_seven_n,
   input wire transmit_power_detect_pin,
   input wire service_mode_pin,
   input wire [2:0] uncommitted_inputs,
   input wire ext_interrupt_zero,
   input wire ext_interrupt_one,
   input wire master_reset_pin_n,
   output wire external_reset_out_n,
   output reg master_reset_active
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function [`CRW_BAUD_ACC_W-1:0] baud_inc;
      input [2:0] sel;
      begin
         case (sel)
            3'h1: baud_inc = 21'd1200 * 21'h2 * `CRW_BAUD_OVERSAMPLE;
            3'h2: baud_inc = 21'd2400 * 21'h2 * `CRW_BAUD_OVERSAMPLE;
            3'h3: baud_inc = 21'd4800 * 21'h2 * `CRW_BAUD_OVERSAMPLE;
            3'h4: baud_inc = 21'd9600 * 21'h2 * `CRW_BAUD_OVERSAMPLE;
            default: baud_inc = 21'd600 * 21'h2 * `CRW_BAUD_OVERSAMPLE;
         endcase
      end
   endfunction

   function [2:0] reg_sel;
      input [31:0] addr;
      begin
         case (addr[`CRW_ADDR_W-1:0])
            `CRW_OFS_INPUT_PORT: reg_sel = 3'h1;
            `CRW_OFS_OUTPUT_PORT: reg_sel = 3'h2;
            `CRW_OFS_PIN_FUNCTION: reg_sel = 3'h3;
            `CRW_OFS_BAUD_SELECT: reg_sel = 3'h4;
            `CRW_OFS_WDOG_CLEAR: reg_sel = 3'h5;
            `CRW_OFS_CLOCK_CONTROL: reg_sel = 3'h6;
            default: reg_sel = 3'h0;
         endcase
         if (addr[31:`CRW_ADDR_W] != 24'h000000) begin
            reg_sel = 3'h0;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   wire [8:0] pin_raw;
   reg [8:0] pin_meta;
   reg [8:0] pin_sync;
   assign pin_raw = {master_reset_pin_n, emulation_mode, processor_clock_pin_in,
                     crystal_input, transmit_power_detect_pin, service_mode_pin,
                     uncommitted_inputs};

   genvar gi;
   generate
      for (gi = 0; gi < 9; gi = gi + 1) begin : g_sync
         always @(posedge aclk) begin
            if (!aresetn) begin
               pin_meta[gi] <= 1'b0;
               pin_sync[gi] <= 1'b0;
            end else begin
               pin_meta[gi] <= pin_raw[gi];
               pin_sync[gi] <= pin_meta[gi];
            end
         end
      end
   endgenerate

   reg [1:0] irq_meta;
   reg [1:0] irq_sync;
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_meta <= 2'h0;
         irq_sync <= 2'h0;
      end else begin
         irq_meta <= {ext_interrupt_one, ext_interrupt_zero};
         irq_sync <= irq_meta;
      end
   end

   wire [2:0] inputs_s = pin_sync[2:0];
   wire service_mode_pin_s = pin_sync[3];
   wire transmit_power_detect_pin_s = pin_sync[4];
   wire xin_s = pin_sync[5];
   wire processor_clock_pin_s = pin_sync[6];
   wire emul_s = pin_sync[7];
   wire mrn_s = pin_sync[8];

   // ----------------------------------------------------------------
   // Registers and master reset
   // ----------------------------------------------------------------
   reg [7:0] output_port;
   reg [7:0] pin_function;
   reg [2:0] baud_sel;
   reg [7:0] clock_control;
   reg [15:0] stretch_ms;
   wire reg_rst = !aresetn || !mrn_s || (stretch_ms != 16'h0000);

   wire turbo = clock_control[`CRW_CC_TURBO];
   wire [7:0] input_port = {transmit_power_detect_pin_s, service_mode_pin_s, 1'b0, inputs_s, irq_sync};

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   reg aw_held;
   reg w_held;
   reg [2:0] aw_sel;
   reg [7:0] w_byte;
   reg w_lane0;
   wire do_write = aw_held && w_held && !s_axi_bvalid;
   wire wr_en = do_write && w_lane0;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_sel <= 3'h0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CRW_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_sel <= reg_sel(s_axi_awaddr);
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_sel == 3'h0 || aw_sel == 3'h1) ? `CRW_RESP_SLVERR
                                                               : `CRW_RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `CRW_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `CRW_RESP_OKAY;
         case (reg_sel(s_axi_araddr))
            3'h1: s_axi_rdata <= {24'h000000, input_port};
            3'h2: s_axi_rdata <= {24'h000000, output_port};
            3'h3: s_axi_rdata <= {24'h000000, pin_function};
            3'h4: s_axi_rdata <= 32'h00000000;
            3'h5: s_axi_rdata <= 32'h00000000;
            3'h6: s_axi_rdata <= {24'h000000, clock_control};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `CRW_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Master reset wipes software state; writes landing during it are lost
   always @(posedge aclk) begin
      if (reg_rst) begin
         output_port <= `CRW_RST_OUTPUT_PORT;
         pin_function <= `CRW_RST_PIN_FUNCTION;
         baud_sel <= `CRW_RST_BAUD_SELECT;
         clock_control <= `CRW_RST_CLOCK_CONTROL;
      end else if (wr_en) begin
         case (aw_sel)
            3'h2: output_port <= w_byte;
            3'h3: pin_function <= w_byte;
            3'h4: baud_sel <= w_byte[2:0];
            3'h6: clock_control <= w_byte;
            default: output_port <= output_port;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Clock generation
   // ----------------------------------------------------------------
   reg xin_prev;
   reg processor_clock_pin_prev;
   reg [2:0] src_div;
   reg main_lvl;
   reg main_prev;
   wire xin_rise = xin_s && !xin_prev;
   wire processor_clock_pin_rise = processor_clock_pin_s && !processor_clock_pin_prev;
   wire main_tick = main_lvl && !main_prev;

   always @(posedge aclk) begin
      if (!aresetn) begin
         xin_prev <= 1'b0;
         processor_clock_pin_prev <= 1'b0;
         src_div <= 3'h0;
         main_lvl <= 1'b0;
         main_prev <= 1'b0;
      end else begin
         xin_prev <= xin_s;
         processor_clock_pin_prev <= processor_clock_pin_s;
         main_prev <= main_lvl;
         if (xin_rise) begin
            src_div <= src_div + 3'h1;
         end
         if (emul_s) begin
            if (!turbo) begin
               main_lvl <= processor_clock_pin_s;
            end else if (processor_clock_pin_rise) begin
               main_lvl <= !main_lvl;
            end
         end else begin
            main_lvl <= src_div[2];
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock and port pins
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         processor_clock_pin_out <= 1'b0;
         processor_clock_pin_oe <= 1'b0;
         buffered_source_clock_out <= 1'b0;
         low_rate_clock_out <= 1'b0;
         oscillator_power_down <= 1'b0;
         crystal_output <= 1'b0;
         pin_output_one <= 1'b0;
         pin_output_two <= 1'b0;
         pin_output_six_n <= 1'b1;
         pin_output_seven_n <= 1'b1;
      end else begin
         processor_clock_pin_out <= turbo ? src_div[1] : src_div[2];
         processor_clock_pin_oe <= !emul_s;
         if (clock_control[`CRW_CC_SRC_CLK_EN]) begin
            buffered_source_clock_out <= xin_s;
         end else begin
            buffered_source_clock_out <= output_port[0];
         end
         low_rate_clock_out <= pin_function[`CRW_PFC_LOWCLK_EN] && main_lvl;
         oscillator_power_down <= pin_function[`CRW_PFC_OSC_PD];
         crystal_output <= !pin_function[`CRW_PFC_OSC_PD] && !xin_s;
         if (pin_function[`CRW_PFC_PULSE_MODULATOR_ONE_SEL]) begin
            pin_output_one <= output_port[1];
         end else begin
            pin_output_one <= pulse_modulator_one;
         end
         case (pin_function[`CRW_PFC_PIN2_SEL_HI:`CRW_PFC_PIN2_SEL_LO])
            `CRW_PIN2_PORT: pin_output_two <= output_port[2];
            `CRW_PIN2_PWM: pin_output_two <= pulse_modulator_two;
            `CRW_PIN2_LATCH: pin_output_two <= serial_latch_two_strobe;
            default: pin_output_two <= 1'b0;
         endcase
         pin_output_six_n <= !output_port[6];
         pin_output_seven_n <= !output_port[7];
      end
   end

   // ----------------------------------------------------------------
   // Baud rate generator
   // ----------------------------------------------------------------
   // Fractional accumulator: the 8x rates of 2400 baud and up do not divide 1.008 MHz evenly
   reg [`CRW_BAUD_ACC_W-1:0] baud_acc;
   wire [`CRW_BAUD_ACC_W-1:0] baud_sum = baud_acc + baud_inc(baud_sel);
   wire baud_wrap = baud_sum >= `CRW_BAUD_MODULUS;

   always @(posedge aclk) begin
      if (reg_rst) begin
         baud_acc <= {`CRW_BAUD_ACC_W{1'b0}};
         baud_clock_out <= 1'b0;
         sci_baud_tick <= 1'b0;
      end else begin
         sci_baud_tick <= 1'b0;
         if (main_tick) begin
            if (baud_wrap) begin
               baud_acc <= baud_sum - `CRW_BAUD_MODULUS;
               baud_clock_out <= !baud_clock_out;
               sci_baud_tick <= !baud_clock_out;
            end else begin
               baud_acc <= baud_sum;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Watchdog and reset stretch
   // ----------------------------------------------------------------
   reg [15:0] prescale;
   reg [15:0] wdog_ms;
   wire ms_tick = main_tick && (prescale == TICKS_PER_MS - 1);
   wire wdog_clear = service_mode_pin_s || !mrn_s || (stretch_ms != 16'h0000) ||
                     (wr_en && aw_sel == 3'h5);

   always @(posedge aclk) begin
      if (!aresetn) begin
         prescale <= 16'h0000;
         wdog_ms <= 16'h0000;
         stretch_ms <= 16'h0000;
         master_reset_active <= 1'b1;
      end else begin
         master_reset_active <= reg_rst;
         if (!mrn_s) begin
            prescale <= 16'h0000;
         end else if (main_tick) begin
            prescale <= ms_tick ? 16'h0000 : prescale + 16'h0001;
         end
         if (wdog_clear) begin
            wdog_ms <= 16'h0000;
         end else if (ms_tick) begin
            wdog_ms <= wdog_ms + 16'h0001;
         end
         if (!mrn_s) begin
            stretch_ms <= STRETCH_MS[15:0];
         end else if (!wdog_clear && ms_tick && wdog_ms == WDOG_MS - 1) begin
            stretch_ms <= STRETCH_MS[15:0];
         end else if (ms_tick && stretch_ms != 16'h0000) begin
            stretch_ms <= stretch_ms - 16'h0001;
         end
      end
   end

   // Raw pin term drops the output without waiting on the synchroniser
   assign external_reset_out_n = master_reset_pin_n && !master_reset_active;

endmodule // crw_clock_reset_watchdog

`default_nettype wire

// file: design/crw_defines.vh
`ifndef CRW_DEFINES_VH
`define CRW_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CRW_ADDR_W 8
`define CRW_OFS_INPUT_PORT 8'h00
`define CRW_OFS_OUTPUT_PORT 8'h04
`define CRW_OFS_PIN_FUNCTION 8'h08
`define CRW_OFS_BAUD_SELECT 8'h0C
`define CRW_OFS_WDOG_CLEAR 8'h10
`define CRW_OFS_CLOCK_CONTROL 8'h14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CRW_RST_OUTPUT_PORT 8'h00
`define CRW_RST_PIN_FUNCTION 8'h03
`define CRW_RST_BAUD_SELECT 3'h0
`define CRW_RST_CLOCK_CONTROL 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CRW_PFC_PULSE_MODULATOR_ONE_SEL 0
`define CRW_PFC_LOWCLK_EN 1
`define CRW_PFC_PIN2_SEL_LO 4
`define CRW_PFC_PIN2_SEL_HI 5
`define CRW_PFC_OSC_PD 6
`define CRW_CC_SRC_CLK_EN 2
`define CRW_CC_TURBO 3
`define CRW_IN_TRANSMIT_POWER_DETECT_PIN 7
`define CRW_IN_SERVICE_MODE_PIN 6

// ----------------------------------------------------------------
// Pin two selector codes
// ----------------------------------------------------------------
`define CRW_PIN2_PORT 2'h0
`define CRW_PIN2_PWM 2'h1
`define CRW_PIN2_LATCH 2'h2

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define CRW_RESP_OKAY 2'h0
`define CRW_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CRW_MAIN_CLOCK_HZ 1008000
`define CRW_TICKS_PER_MS (`CRW_MAIN_CLOCK_HZ / 1000)
`define CRW_WDOG_PERIOD_MS 4000
`define CRW_RESET_STRETCH_MS 100
`define CRW_BAUD_OVERSAMPLE 21'h08
`define CRW_BAUD_ACC_W 21
// Main clock rate at accumulator width
`define CRW_BAUD_MODULUS 21'hF6180

`endif

// file: test/crw_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module crw_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic crystal_output,
   input wire logic oscillator_power_down,
   input wire logic emulation_mode,
   input wire logic processor_clock_pin_oe,
   input wire logic pin_output_six_n,
   input wire logic pin_output_seven_n,
   input wire logic master_reset_pin_n,
   input wire logic external_reset_out_n,
   input wire logic master_reset_active
);
   // ----------------------------------------
   // Port relations
   // ----------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
   a_busy_no_take: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_bresp_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not retired");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_rresp_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response not retired");
   a_pin_low_drop: assert property (!master_reset_pin_n |-> !external_reset_out_n)
      else $error("reset output high while pin low");
   a_master_drop: assert property (master_reset_active |-> !external_reset_out_n)
      else $error("reset output high during master reset");
   a_pin_stretch: assert property ($rose(master_reset_pin_n) |-> !external_reset_out_n [*8])
      else $error("reset output not stretched");
   a_reset_leds_high: assert property (master_reset_active [*3] |->
      pin_output_six_n && pin_output_seven_n)
      else $error("inverted pins low in reset");
   a_osc_down_quiet: assert property (oscillator_power_down [*3] |-> !crystal_output)
      else $error("crystal output active while powered down");
   a_emul_pin_dir: assert property ($past(aresetn, 3) |->
      processor_clock_pin_oe == !$past(emulation_mode, 3))
      else $error("processor clock pin direction wrong");
endmodule // crw_monitor

bind crw_clock_reset_watchdog crw_monitor i_monitor (.*);
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "crw_defines.vh"
module tb_top;
   localparam int TPM = 4;
   // Main tick is 64 aclk cycles with the source clock below
   localparam int STR = 3 * TPM * 64;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [2:0] s_axi_awprot, s_axi_arprot, uncommitted_inputs;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic crystal_input, crystal_output, oscillator_power_down, emulation_mode;
   logic processor_clock_pin_in, processor_clock_pin_out, processor_clock_pin_oe;
   logic buffered_source_clock_out, low_rate_clock_out, baud_clock_out, sci_baud_tick;
   logic pulse_modulator_one, pulse_modulator_two, serial_latch_two_strobe;
   logic pin_output_one, pin_output_two, pin_output_six_n, pin_output_seven_n;
   logic transmit_power_detect_pin, service_mode_pin, ext_interrupt_zero, ext_interrupt_one;
   logic master_reset_pin_n, external_reset_out_n, master_reset_active;
   int err_total, cmp_count, n;

   crw_clock_reset_watchdog #(.TICKS_PER_MS(TPM), .WDOG_MS(8), .STRETCH_MS(3)) i_dut (.*);

   // ----------------------------------------
   // Clocks
   // ----------------------------------------
   initial begin
      aclk = 0;
      forever #4 aclk = ~aclk;
   end
   initial begin
      crystal_input = 0;
      forever #32 crystal_input = ~crystal_input;
   end

   // ----------------------------------------
   // Bus and helper tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st = 4'hF,
                     input logic [1:0] er = `CRW_RESP_OKAY);
      logic awd, wd;
      awd = 0;
      wd = 0;
      @(posedge aclk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(awd && wd)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            awd = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check(s_axi_bresp, er);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er = `CRW_RESP_OKAY);
      @(posedge aclk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, exp);
      check(s_axi_rresp, er);
   endtask
   task automatic rises(input int sel, input int k, output int c);
      logic p, v;
      c = 0;
      p = 1;
      repeat (k) begin
         @(posedge aclk);
         case (sel)
            0: v = low_rate_clock_out;
            1: v = buffered_source_clock_out;
            default: v = processor_clock_pin_out;
         endcase
         if (v && !p)
            c++;
         p = v;
      end
   endtask
   task automatic low_span(output int c);
      c = 0;
      while (!external_reset_out_n && c < 5000) begin
         @(posedge aclk);
         c++;
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_defaults;
      check(pin_output_six_n, 1);
      check(pin_output_seven_n, 1);
      check(buffered_source_clock_out, 0);
      check(oscillator_power_down, 0);
      rc(8'h08, 8'h03);
      rc(8'h14, 0);
      rc(8'h04, 0);
      rc(8'h0C, 0);
      rc(8'h18, 0, `CRW_RESP_SLVERR);
      wr(8'h00, 8'hFF, 4'hF, `CRW_RESP_SLVERR);
      wr(8'h04, 8'hFF, 4'h0);
      rc(8'h04, 0);
      $display("defaults done");
   endtask
   task automatic t_inputs;
      logic [7:0] p;
      for (int i = 0; i < 2; i++) begin
         p = i ? 8'h4A : 8'h95;
         transmit_power_detect_pin <= p[7];
         service_mode_pin <= p[6];
         uncommitted_inputs <= p[4:2];
         ext_interrupt_one <= p[1];
         ext_interrupt_zero <= p[0];
         cyc(4);
         rc(8'h00, p);
      end
      $display("inputs done");
   endtask
   task automatic t_mux;
      logic e;
      wr(8'h04, 8'hC7);
      cyc(2);
      check(pin_output_six_n, 0);
      check(pin_output_seven_n, 0);
      check(pin_output_one, 1);
      check(buffered_source_clock_out, 1);
      for (int c = 0; c < 4; c++) begin
         for (int ph = 0; ph < 2; ph++) begin
            wr(8'h08, {2'b00, c[1:0], 4'b0010});
            pulse_modulator_one <= ph[0];
            pulse_modulator_two <= !ph[0];
            serial_latch_two_strobe <= ph[0];
            cyc(2);
            e = (c == 0) ? 1'b1 : (c == 1) ? !ph[0] : (c == 2) ? ph[0] : 1'b0;
            check(pin_output_two, e);
            check(pin_output_one, ph[0]);
         end
      end
      wr(8'h08, 8'h00);
      rises(0, 640, n);
      check(n, 0);
      check(low_rate_clock_out, 0);
      wr(8'h08, 8'h03);
      rises(0, 640, n);
      check(n >= 9 && n <= 11, 1);
      wr(8'h08, 8'h43);
      cyc(4);
      check(oscillator_power_down, 1);
      check(crystal_output, 0);
      wr(8'h08, 8'h03);
      $display("pin mux done");
   endtask
   task automatic t_clocks;
      wr(8'h14, 8'h04);
      rises(1, 64, n);
      check(n >= 7 && n <= 9, 1);
      rises(2, 640, n);
      check(n >= 9 && n <= 11, 1);
      wr(8'h14, 8'h0C);
      rises(2, 640, n);
      check(n >= 19 && n <= 21, 1);
      wr(8'h14, 8'h00);
      cyc(2);
      check(buffered_source_clock_out, 1);
      emulation_mode <= 1'b1;
      cyc(4);
      check(processor_clock_pin_oe, 0);
      for (int t = 0; t < 2; t++) begin
         wr(8'h14, t ? 8'h08 : 8'h00);
         fork
            for (int i = 0; i < 640; i++) begin
               processor_clock_pin_in <= i[4];
               @(posedge aclk);
            end
            rises(0, 640, n);
         join
         check(n >= 19 - 10 * t && n <= 21 - 10 * t, 1);
      end
      wr(8'h14, 8'h00);
      emulation_mode <= 1'b0;
      $display("clocks done");
   endtask
   task automatic t_baud;
      int p, x;
      for (int c = 4; c >= 0; c--) begin
         wr(8'h0C, c[7:0]);
         repeat (2) begin
            p = 0;
            do begin
               @(posedge aclk);
               p++;
            end while (!sci_baud_tick && p < 30000);
         end
         check(baud_clock_out, 1);
         // One main tick of jitter from the fractional accumulator
         x = 13440 >> c;
         check(p >= x - 80 && p <= x + 80, 1);
      end
      check(master_reset_active, 0);
      $display("baud done");
   endtask
   task automatic t_wdog;
      wr(8'h08, 8'h33);
      service_mode_pin <= 1'b0;
      repeat (4) begin
         cyc(1200);
         wr(8'h10, 8'h5A);
      end
      check(master_reset_active, 0);
      n = 0;
      while (!master_reset_active && n < 2400) begin
         @(posedge aclk);
         n++;
      end
      check(n >= 1750 && n <= 2120, 1);
      check(external_reset_out_n, 0);
      low_span(n);
      check(n >= STR - 300 && n <= STR + 300, 1);
      check(pin_output_six_n, 1);
      rc(8'h08, 8'h03);
      service_mode_pin <= 1'b1;
      $display("watchdog done");
   endtask
   task automatic t_pin;
      wr(8'h04, 8'hC0);
      master_reset_pin_n <= 1'b0;
      #1;
      check(external_reset_out_n, 0);
      cyc(500);
      check(master_reset_active, 1);
      master_reset_pin_n <= 1'b1;
      low_span(n);
      check(n >= STR - 300 && n <= STR + 300, 1);
      rc(8'h04, 0);
      $display("pin reset done");
   endtask

   // ----------------------------------------
   // Sequence and verdict
   // ----------------------------------------
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      err_total = 0;
      cmp_count = 0;
      aresetn = 0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {s_axi_awprot, s_axi_arprot, uncommitted_inputs} = '0;
      s_axi_wstrb = 4'hF;
      {emulation_mode, processor_clock_pin_in, transmit_power_detect_pin} = '0;
      {pulse_modulator_one, pulse_modulator_two, serial_latch_two_strobe} = '0;
      {ext_interrupt_zero, ext_interrupt_one} = '0;
      // Service mode keeps the watchdog quiet except in its own test
      service_mode_pin = 1;
      master_reset_pin_n = 1;
      cyc(6);
      aresetn <= 1'b1;
      cyc(4);
      n = 0;
      while (master_reset_active && n < 3000) begin
         @(posedge aclk);
         n++;
      end
      cyc(2);
      check(master_reset_active, 0);
      t_defaults();
      t_inputs();
      t_mux();
      t_clocks();
      t_baud();
      t_wdog();
      t_pin();
      summarize();
   end
   // Tests need about 65k cycles; cut off at 100k
   initial begin
      #800000;
      err_total++;
      summarize();
   end
endmodule // tb_top
`default_nettype wire
